// file: rtl/addr_filter.sv
/*
  Destination address filter: unicast, group hash, all-ones and combined hit.
  Assumes start_i marks the first destination byte and take_i each later byte.
*/
`timescale 1ns/1ps
module addr_filter (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        start_i,
  input  wire logic        take_i,
  input  wire logic [7:0]  data_i,
  input  wire logic [47:0] station_i,
  input  wire logic [63:0] group_filter_bits_i,
  input  wire logic        accept_all_ones_en_i,
  input  wire logic        accept_group_en_i,
  input  wire logic        accept_everything_en_i,
  output logic             combined_hit_o,
  output logic             group_addr_o
);
  import rx_ring_pkg::*;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction : crc_byte

  logic [2:0]  idx_reg;
  logic [31:0] crc_reg;
  logic        uni_reg;
  logic        ones_reg;
  logic        grp_reg;
  logic        more;
  logic        done;
  logic        uni_hit;
  logic        ones_hit;
  logic        mul_hit;
  logic [7:0]  sta_byte;

  assign more     = take_i && (idx_reg != DA_BYTES) && (idx_reg != 3'h0);
  assign sta_byte = start_i ? station_i[7:0] : station_i[{idx_reg, 3'b000} +: 8];
  assign done     = (idx_reg == DA_BYTES);
  assign uni_hit  = done && uni_reg;
  assign ones_hit = done && ones_reg;
  assign mul_hit  = done && grp_reg && group_filter_bits_i[crc_reg[31:26]];
  assign combined_hit_o = uni_hit || (mul_hit && accept_group_en_i)
                       || (ones_hit && accept_all_ones_en_i) || (done && accept_everything_en_i);
  assign group_addr_o   = grp_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_reg  <= 3'h0;
      crc_reg  <= CRC_INIT;
      uni_reg  <= 1'b0;
      ones_reg <= 1'b0;
      grp_reg  <= 1'b0;
    end else if (start_i) begin
      idx_reg  <= 3'h1;
      crc_reg  <= crc_byte(CRC_INIT, data_i);
      uni_reg  <= (data_i == sta_byte);
      ones_reg <= (data_i == 8'hFF);
      grp_reg  <= data_i[0];
    end else if (more) begin
      idx_reg  <= idx_reg + 3'h1;
      crc_reg  <= crc_byte(crc_reg, data_i);
      uni_reg  <= uni_reg && (data_i == sta_byte);
      ones_reg <= ones_reg && (data_i == 8'hFF);
    end
  end

  everything_hit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (accept_everything_en_i && done) |-> combined_hit_o)
    else $error("promiscuous frame not matched");
endmodule : addr_filter

// file: rtl/page_step.sv
/*
  Next-page arithmetic for the receive ring.
  Assumes page numbers are the upper eight bits of the buffer address.
*/
`timescale 1ns/1ps
module page_step (
  input  wire logic [7:0] page_i,
  input  wire logic [7:0] first_i,
  input  wire logic [7:0] end_i,
  input  wire logic [7:0] bound_i,
  output logic      [7:0] next_o,
  output logic            hit_bound_o
);
  logic [7:0] inc;
  assign inc         = page_i + 8'h01;
  assign next_o      = (inc == end_i) ? first_i : inc;
  assign hit_bound_o = (next_o == bound_i);
endmodule : page_step

// file: rtl/rx_ring_manager.sv
/*
  Receive buffer ring manager: stores filtered frames in 256-byte pages,
  writes the 4-byte header, recovers rejected frames, AHB-Lite registers.
  Assumes the MAC delivers one byte per beat, FCS included, eof on the last.
*/
`timescale 1ns/1ps
module rx_ring_manager (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  output logic [31:0]                hrdata_o,
  input  wire rx_ring_pkg::rx_beat_t rx_i,
  output logic                       rx_ready_o,
  output rx_ring_pkg::mem_wr_t       mem_o
);
  import rx_ring_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_reg;
  logic [7:0]  ring_first_page_reg;
  logic [7:0]  ring_end_page_reg;
  logic [7:0]  write_page_pointer_reg;
  logic [7:0]  bnd_reg;
  logic [1:0]  event_flag_register_reg;
  logic [47:0] station_reg;
  logic [63:0] group_filter_bits_reg;
  logic        dp_wr_reg;
  logic [7:0]  dp_addr_reg;
  rx_state_t   state_reg;
  rx_state_t   state_next;
  logic [7:0]  page_reg;
  logic [7:0]  page_next;
  logic [7:0]  off_reg;
  logic [7:0]  off_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [1:0]  hdr_reg;
  logic [1:0]  hdr_next;
  logic [7:0]  scratch_reg;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [1:0]  event_next;
  mem_wr_t     mem_next;
  logic [31:0] rd_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic ap_take;
  logic w_ctrl;
  logic w_first;
  logic w_end;
  logic w_wpp;
  logic w_bnd;
  logic w_event;
  logic w_sta_lo;
  logic w_sta_hi;
  logic w_grp_lo;
  logic w_grp_hi;

  assign ap_take  = hsel_i && htrans_i[1] && hready_i;
  assign w_ctrl   = dp_wr_reg && (dp_addr_reg == OFF_CTRL);
  assign w_first  = dp_wr_reg && (dp_addr_reg == OFF_FIRST);
  assign w_end    = dp_wr_reg && (dp_addr_reg == OFF_END);
  assign w_wpp    = dp_wr_reg && (dp_addr_reg == OFF_WPP);
  assign w_bnd    = dp_wr_reg && (dp_addr_reg == OFF_BND);
  assign w_event  = dp_wr_reg && (dp_addr_reg == OFF_EVENT);
  assign w_sta_lo = dp_wr_reg && (dp_addr_reg == OFF_STA_LO);
  assign w_sta_hi = dp_wr_reg && (dp_addr_reg == OFF_STA_HI);
  assign w_grp_lo = dp_wr_reg && (dp_addr_reg == OFF_GRP_LO);
  assign w_grp_hi = dp_wr_reg && (dp_addr_reg == OFF_GRP_HI);

  always_comb begin
    case (haddr_i[7:0])
      OFF_CTRL:   rd_next = {24'h000000, ctrl_reg};
      OFF_FIRST:  rd_next = {24'h000000, ring_first_page_reg};
      OFF_END:    rd_next = {24'h000000, ring_end_page_reg};
      OFF_WPP:    rd_next = {24'h000000, write_page_pointer_reg};
      OFF_BND:    rd_next = {24'h000000, bnd_reg};
      OFF_EVENT:  rd_next = {30'h0000000, event_flag_register_reg};
      OFF_STA_LO: rd_next = station_reg[31:0];
      OFF_STA_HI: rd_next = {16'h0000, station_reg[47:32]};
      OFF_GRP_LO: rd_next = group_filter_bits_reg[31:0];
      OFF_GRP_HI: rd_next = group_filter_bits_reg[63:32];
      OFF_STAT:   rd_next = {cnt_reg, status_reg, 7'h00, state_reg != S_IDLE};
      default:    rd_next = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Filter and page arithmetic
  // ----------------------------------------------------------------
  logic       start_ok;
  logic       take;
  logic       combined_hit;
  logic       group_addr;
  logic [7:0] step_page;
  logic       hit_bound;
  logic       link;
  logic       abort;
  logic       frame_end;
  logic       bad;
  logic       keep;
  logic       hdr_done;
  logic [7:0] hdr_byte;

  assign start_ok  = (state_reg == S_IDLE) && rx_i.valid && rx_i.sof && !ctrl_reg[CTL_HALT];
  assign take      = (state_reg == S_RECV) && rx_i.valid;
  assign link      = take && (off_reg == LAST_OFF) && !rx_i.eof;
  assign abort     = link && hit_bound;
  assign frame_end = take && rx_i.eof;
  assign bad       = (rx_i.runt && !ctrl_reg[CTL_RUNT])
                  || ((rx_i.crc_err || rx_i.align_err) && !ctrl_reg[CTL_ERR]);
  assign keep      = frame_end && combined_hit && !bad;
  assign hdr_done  = (state_reg == S_HDR) && (hdr_reg == HDR_LAST);
  assign hdr_byte  = (hdr_reg == 2'h0) ? status_reg :
                     (hdr_reg == 2'h1) ? scratch_reg :
                     (hdr_reg == 2'h2) ? cnt_reg[7:0] : cnt_reg[15:8];

  addr_filter filter_u (
    .clk_i                  (clk_i),
    .reset_n_i              (reset_n_i),
    .start_i                (start_ok),
    .take_i                 (take),
    .data_i                 (rx_i.data),
    .station_i              (station_reg),
    .group_filter_bits_i    (group_filter_bits_reg),
    .accept_all_ones_en_i   (ctrl_reg[CTL_ONES]),
    .accept_group_en_i      (ctrl_reg[CTL_GROUP]),
    .accept_everything_en_i (ctrl_reg[CTL_EVERY]),
    .combined_hit_o         (combined_hit),
    .group_addr_o           (group_addr)
  );

  page_step step_u (
    .page_i      (page_reg),
    .first_i     (ring_first_page_reg),
    .end_i       (ring_end_page_reg),
    .bound_i     (bnd_reg),
    .next_o      (step_page),
    .hit_bound_o (hit_bound)
  );

  // ----------------------------------------------------------------
  // Receive sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    page_next   = page_reg;
    off_next    = off_reg;
    cnt_next    = cnt_reg;
    hdr_next    = hdr_reg;
    mem_next    = '0;
    status_next = 8'h00;
    status_next[ST_OK]    = !(rx_i.crc_err || rx_i.align_err);
    status_next[ST_CRC]   = rx_i.crc_err;
    status_next[ST_ALIGN] = rx_i.align_err;
    status_next[ST_GROUP] = group_addr;
    case (state_reg)
      S_IDLE: begin
        if (start_ok) begin
          state_next = S_RECV;
          page_next  = write_page_pointer_reg;
          off_next   = HDR_GAP + 8'h01;
          cnt_next   = 16'h0001;
          mem_next   = '{1'b1, {write_page_pointer_reg, HDR_GAP}, rx_i.data};
        end
      end
      S_RECV: begin
        if (rx_i.valid) begin
          mem_next = '{1'b1, {page_reg, off_reg}, rx_i.data};
          off_next = off_reg + 8'h01;
          cnt_next = cnt_reg + 16'h0001;
          if (frame_end) begin
            state_next = keep ? S_HDR : S_IDLE;
            hdr_next   = 2'h0;
          end else if (abort) begin
            state_next = S_DROP;
          end else if (link) begin
            page_next = step_page;
          end
        end
      end
      S_DROP: begin
        if (rx_i.valid && rx_i.eof) begin
          state_next = S_IDLE;
        end
      end
      S_HDR: begin
        mem_next = '{1'b1, {write_page_pointer_reg, 6'h00, hdr_reg}, hdr_byte};
        hdr_next = hdr_reg + 2'h1;
        if (hdr_reg == HDR_LAST) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Set wins over a same-cycle clear
  assign event_next = (event_flag_register_reg & ~(w_event ? hwdata_i[1:0] : 2'b00))
                    | {hdr_done, abort};

  // ----------------------------------------------------------------
  // State flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg   <= S_IDLE;
      page_reg    <= 8'h00;
      off_reg     <= 8'h00;
      cnt_reg     <= 16'h0000;
      hdr_reg     <= 2'h0;
      scratch_reg <= 8'h00;
      status_reg  <= 8'h00;
      mem_o       <= '0;
      rx_ready_o  <= 1'b1;
    end else begin
      state_reg  <= state_next;
      page_reg   <= page_next;
      off_reg    <= off_next;
      cnt_reg    <= cnt_next;
      hdr_reg    <= hdr_next;
      mem_o      <= mem_next;
      rx_ready_o <= (state_next != S_HDR);
      if (frame_end) begin
        scratch_reg <= step_page;
        status_reg  <= status_next;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      write_page_pointer_reg <= WPP_RST;
    end else if (hdr_done) begin
      write_page_pointer_reg <= scratch_reg;
    end else if (w_wpp) begin
      write_page_pointer_reg <= hwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Software registers and bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg                <= CTRL_RST;
      ring_first_page_reg     <= FIRST_RST;
      ring_end_page_reg       <= END_RST;
      bnd_reg                 <= BND_RST;
      event_flag_register_reg <= 2'b00;
      station_reg             <= 48'h000000000000;
      group_filter_bits_reg   <= 64'h0000000000000000;
    end else begin
      event_flag_register_reg <= event_next;
      if (w_ctrl)   ctrl_reg                     <= hwdata_i[7:0];
      if (w_first)  ring_first_page_reg          <= hwdata_i[7:0];
      if (w_end)    ring_end_page_reg            <= hwdata_i[7:0];
      if (w_bnd)    bnd_reg                      <= hwdata_i[7:0];
      if (w_sta_lo) station_reg[31:0]            <= hwdata_i;
      if (w_sta_hi) station_reg[47:32]           <= hwdata_i[15:0];
      if (w_grp_lo) group_filter_bits_reg[31:0]  <= hwdata_i;
      if (w_grp_hi) group_filter_bits_reg[63:32] <= hwdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      dp_wr_reg   <= ap_take && hwrite_i;
      dp_addr_reg <= haddr_i[7:0];
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (ap_take && !hwrite_i) begin
        hrdata_o <= rd_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence hdr_walk_s;
    mem_o.we && mem_o.addr[7:0] == 8'h00 ##1 mem_o.we && mem_o.addr[7:0] == 8'h01
    ##1 mem_o.we && mem_o.addr[7:0] == 8'h02 ##1 mem_o.we && mem_o.addr[7:0] == 8'h03;
  endsequence

  header_gap_a: assert property (start_ok |=> mem_o.we &&
    mem_o.addr == {$past(write_page_pointer_reg), HDR_GAP})
    else $error("first byte not after header gap");
  header_walk_a: assert property (keep |=> ##1 hdr_walk_s)
    else $error("header bytes not written in order");
  pointer_load_a: assert property (hdr_done |=> write_page_pointer_reg == $past(scratch_reg))
    else $error("write page pointer not loaded");
  reject_rewind_a: assert property ((frame_end && !keep && !w_wpp) |=>
    $stable(write_page_pointer_reg) && state_reg == S_IDLE)
    else $error("rejected frame moved the pointer");
  overrun_flag_a: assert property (abort |=> event_flag_register_reg[EVT_OVR] && state_reg == S_DROP)
    else $error("overrun not flagged");
  ring_wrap_a: assert property ((link && !abort && page_reg + 8'h01 == ring_end_page_reg) |=>
    page_reg == ring_first_page_reg)
    else $error("ring did not wrap");
  halt_hold_a: assert property ((ctrl_reg[CTL_HALT] && state_reg == S_IDLE) |=> state_reg == S_IDLE)
    else $error("frame started while halted");
  fcs_store_a: assert property (frame_end |=> mem_o.we && mem_o.data == $past(rx_i.data))
    else $error("last byte not stored");
endmodule : rx_ring_manager

// file: rtl/rx_ring_pkg.sv
/*
  Constants, carrier types and states for the receive ring manager.
  Assumes one 50 MHz core clock and an 8-bit wide buffer write port.
*/
package rx_ring_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FIRST  = 8'h04;
  localparam logic [7:0] OFF_END    = 8'h08;
  localparam logic [7:0] OFF_WPP    = 8'h0C;
  localparam logic [7:0] OFF_BND    = 8'h10;
  localparam logic [7:0] OFF_EVENT  = 8'h14;
  localparam logic [7:0] OFF_STA_LO = 8'h18;
  localparam logic [7:0] OFF_STA_HI = 8'h1C;
  localparam logic [7:0] OFF_GRP_LO = 8'h20;
  localparam logic [7:0] OFF_GRP_HI = 8'h24;
  localparam logic [7:0] OFF_STAT   = 8'h28;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_HALT  = 0;
  localparam int CTL_ONES  = 1;
  localparam int CTL_GROUP = 2;
  localparam int CTL_EVERY = 3;
  localparam int CTL_RUNT  = 4;
  localparam int CTL_ERR   = 5;
  localparam int EVT_OVR   = 0;
  localparam int EVT_RX    = 1;
  localparam int ST_OK     = 0;
  localparam int ST_CRC    = 1;
  localparam int ST_ALIGN  = 2;
  localparam int ST_GROUP  = 5;
  // ----------------------------------------------------------------
  // Reset values and frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST  = 8'h01;
  localparam logic [7:0]  FIRST_RST = 8'h40;
  localparam logic [7:0]  END_RST   = 8'h80;
  localparam logic [7:0]  WPP_RST   = 8'h40;
  localparam logic [7:0]  BND_RST   = 8'h40;
  localparam logic [7:0]  HDR_GAP   = 8'h04;
  localparam logic [7:0]  LAST_OFF  = 8'hFF;
  localparam logic [1:0]  HDR_LAST  = 2'h3;
  localparam logic [2:0]  DA_BYTES  = 3'h6;
  localparam logic [31:0] CRC_INIT  = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY  = 32'h04C11DB7;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       sof;
    logic       eof;
    logic       runt;
    logic       crc_err;
    logic       align_err;
  } rx_beat_t;
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_wr_t;
  typedef enum logic [1:0] {S_IDLE, S_RECV, S_DROP, S_HDR} rx_state_t;
endpackage : rx_ring_pkg

// file: sim/mac_rx_model.sv
/* MAC receive path model: one byte a cycle, FCS last.
   Assumes send is called just after a rising clock edge.
   Error bits on the eof beat: 0 runt, 1 crc, 2 align. */
`timescale 1ns/1ps
module mac_rx_model (
  input  wire logic             clk_i,
  output rx_ring_pkg::rx_beat_t rx_o
);
  import rx_ring_pkg::*;
  initial rx_o = '0;
  task automatic send(input logic [47:0] da, input int n, input logic [2:0] bad);
    for (int i = 0; i < n; i++) begin
      rx_o.data <= (i < 6) ? da[8*i +: 8] : 8'(i);
      rx_o.valid <= 1'b1;
      rx_o.sof <= (i == 0);
      rx_o.eof <= (i == n - 1);
      rx_o.runt <= bad[0] && (i == n - 1);
      rx_o.crc_err <= bad[1] && (i == n - 1);
      rx_o.align_err <= bad[2] && (i == n - 1);
      @(posedge clk_i);
    end
    // Idle bus shows no stale byte
    rx_o <= '{data: ~rx_o.data, default: '0};
  endtask : send
endmodule : mac_rx_model

// file: sim/tb_top.sv
/* Bench for the receive ring manager: AHB-Lite tasks, frame tests.
   Assumes one slave, so hreadyout is the bus hready. */
`timescale 1ns/1ps
module tb_top;
  import rx_ring_pkg::*;
  localparam logic [47:0] STA = 48'h0A0B0C0D0E10;
  localparam logic [7:0] CFG [4] = '{8'h00, 8'h02, 8'h04, 8'h08};
  localparam logic [47:0] DAS [4] = '{'1, '1, 48'h1, 48'h6};
  localparam logic [7:0] STS [4] = '{8'h00, 8'h21, 8'h21, 8'h01};
  // Host overflow recovery wait: 1.5 ms of 20 ns cycles
  localparam int RECOVER_WAIT = 75000;
  logic clk_i = 0, reset_n_i = 0, hsel = 0, hwrite = 0, hready, hresp, rdy, rdy_low;
  logic send_request_bit = 0, frame_sent_flag = 0, send_fault_flag = 0, resend;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  rx_beat_t rx;
  mem_wr_t mw;
  logic [7:0] mem [logic [15:0]];
  logic [7:0] p;
  int n_mismatch = 0, n_compared = 0;
  always #10 clk_i = ~clk_i;
  // Capture of buffer writes
  always @(posedge clk_i) if (mw.we) mem[mw.addr] = mw.data;
  rx_ring_manager i_dut (.clk_i, .reset_n_i, .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .rx_i(rx), .rx_ready_o(rdy), .mem_o(mw));
  mac_rx_model i_mac (.clk_i, .rx_o(rx));
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(rd, e);
  endtask : rchk
  task automatic frame(input logic [47:0] da, input int n, input logic [2:0] bad);
    mem.delete();
    i_mac.send(da, n, bad);
    @(posedge clk_i);
    rdy_low = !rdy;
    repeat (7) @(posedge clk_i);
  endtask : frame
  function automatic logic [7:0] nxt(input logic [7:0] q);
    return (q + 8'h01 == 8'h43) ? 8'h40 : q + 8'h01;
  endfunction : nxt
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (RECOVER_WAIT + 15000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1;
    @(posedge clk_i);
    rchk(OFF_CTRL, CTRL_RST);
    rchk(OFF_FIRST, FIRST_RST);
    rchk(OFF_END, END_RST);
    rchk(OFF_WPP, WPP_RST);
    rchk(OFF_BND, BND_RST);
    rchk(8'h3C, 0);
    chk(hresp, 0);
    $display("reset test done");
    bus(1, OFF_STA_LO, STA[31:0]);
    bus(1, OFF_STA_HI, {16'h0, STA[47:32]});
    bus(1, OFF_END, 32'h43);
    bus(1, OFF_WPP, 32'h41);
    bus(1, OFF_BND, 32'h4F);
    bus(1, OFF_CTRL, 0);
    frame(STA, 64, 0);
    chk(rdy_low, 1);
    chk(rdy, 1);
    chk(mem[16'h4104], 8'h10);
    chk(mem[16'h4143], 8'h3F);
    chk({mem[16'h4103], mem[16'h4102], mem[16'h4101], mem[16'h4100]}, 32'h00404201);
    rchk(OFF_WPP, 8'h42);
    rchk(OFF_STAT, 32'h00400100);
    frame(STA, 300, 0);
    chk(mem[16'h4000], 8'hFC);
    chk({mem[16'h4203], mem[16'h4202], mem[16'h4201], mem[16'h4200]}, 32'h012C4101);
    rchk(OFF_WPP, 8'h41);
    $display("ring test done");
    bus(1, OFF_GRP_LO, '1);
    bus(1, OFF_GRP_HI, '1);
    p = 8'h41;
    foreach (CFG[i]) begin
      bus(1, OFF_CTRL, CFG[i]);
      frame(DAS[i], 64, 0);
      if (CFG[i] != 0) begin
        chk(mem[{p, 8'h00}], STS[i]);
        p = nxt(p);
      end
      rchk(OFF_WPP, p);
    end
    $display("filter test done");
    bus(1, OFF_CTRL, 0);
    frame(STA, 100, 3'h2);
    chk(rdy_low, 0);
    rchk(OFF_WPP, p);
    chk(mem.exists({p, 8'h00}), 0);
    bus(1, OFF_CTRL, 32'h20);
    frame(STA, 100, 3'h2);
    chk(mem[{p, 8'h00}], 8'h02);
    p = nxt(p);
    rchk(OFF_WPP, p);
    frame(STA, 100, 3'h4);
    chk(mem[{p, 8'h00}], 8'h04);
    p = nxt(p);
    bus(1, OFF_CTRL, 0);
    frame(STA, 64, 3'h1);
    rchk(OFF_WPP, p);
    bus(1, OFF_CTRL, 32'h10);
    frame(STA, 64, 3'h1);
    chk(mem[{p, 8'h00}], 8'h01);
    p = nxt(p);
    rchk(OFF_WPP, p);
    $display("reject test done");
    bus(1, OFF_CTRL, 0);
    bus(1, OFF_EVENT, 3);
    bus(1, OFF_BND, {24'h0, nxt(p)});
    frame(STA, 300, 0);
    rchk(OFF_WPP, p);
    rchk(OFF_EVENT, 1);
    chk(mem.exists({p, 8'h00}), 0);
    // Stop lands while a frame is still arriving
    fork
      i_mac.send(STA, 64, 0);
      begin
        repeat (10) @(posedge clk_i);
        bus(1, OFF_CTRL, 1);
      end
    join
    repeat (8) @(posedge clk_i);
    p = nxt(p);
    rchk(OFF_WPP, p);
    frame(STA, 64, 0);
    rchk(OFF_WPP, p);
    repeat (RECOVER_WAIT) @(posedge clk_i);
    resend = send_request_bit && !(frame_sent_flag || send_fault_flag);
    bus(1, OFF_CTRL, 0);
    bus(1, OFF_BND, {24'h0, p});
    bus(1, OFF_EVENT, 1);
    rchk(OFF_EVENT, 2);
    frame(STA, 300, 0);
    rchk(OFF_WPP, nxt(nxt(p)));
    rchk(OFF_EVENT, 2);
    if (resend) bus(1, OFF_CTRL, 0);
    $display("overflow test done");
    end_of_test();
  end
endmodule : tb_top
